/* logic/pmc_bus_slave.sv */
// avalon-mm slave handshake, one wait cycle per access
`timescale 1ns/1ps
module pmc_bus_slave
   import pmc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] rdata_in,
   output      logic        avs_waitrequest,
   output      logic [31:0] avs_readdata,
   output      logic        wr_fire
);

   pmc_bus_state_type s_r;
   pmc_bus_state_type s_nxt;

   logic req;

   assign req             = avs_read || avs_write;
   assign avs_waitrequest = req && !s_r.ack;
   assign avs_readdata    = s_r.rdata;
   assign wr_fire         = avs_write && s_r.ack;

   always_comb
   begin
      s_nxt     = s_r;
      s_nxt.ack = req && !s_r.ack;
      // capture read data one edge before completion so it stands at that edge
      if (avs_read && !s_r.ack)
         s_nxt.rdata = rdata_in;
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

endmodule

/* logic/pmc_clk_div.sv */
// step divider giving one tick every divisor+1 steps
`timescale 1ns/1ps
module pmc_clk_div
   import pmc_pkg::*;
#(
   parameter int W = 5
)
(
   input  wire logic         core_clk,
   input  wire logic         reset_n,
   input  wire logic         step,
   input  wire logic [W-1:0] divisor,
   output      logic         tick
);

   typedef struct packed
   {
      logic [W-1:0] cnt;
   } pmc_div_state_type;

   pmc_div_state_type s_r;
   pmc_div_state_type s_nxt;

   // >= keeps it safe when software shrinks the divisor mid-count
   assign tick = step && (s_r.cnt >= divisor);

   always_comb
   begin
      s_nxt = s_r;
      if (step)
      begin
         if (tick)
            s_nxt.cnt = '0;
         else
            s_nxt.cnt = W'(s_r.cnt + 1'b1);
      end
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

endmodule

/* logic/pmc_pkg.sv */
// shared constants and types of the power mode and clock gating block
package pmc_pkg;

   // register map, byte addresses on the avalon slave
   localparam int          PMC_ADDR_W      = 4;
   localparam logic [3:0]  PMC_OFS_CTRL    = 4'h0;
   localparam logic [3:0]  PMC_OFS_STATUS  = 4'h4;

   // control register fields
   localparam int          PMC_CTRL_SLOW_POS = 0;
   localparam int          PMC_CTRL_CPU_POS  = 4;
   localparam int          PMC_CTRL_CCU_POS  = 8;
   localparam int          PMC_CTRL_WFI_POS  = 12;
   localparam int          PMC_DIV_W         = 4;

   // status register fields
   localparam int          PMC_STAT_MODE_POS = 0;
   localparam int          PMC_STAT_WDG_POS  = 2;
   localparam int          PMC_STAT_HREF_POS = 4;

   // reset values
   localparam logic [15:0] PMC_CTRL_RST      = 16'h0000;
   localparam logic        PMC_HREF_RST      = 1'b0;
   // reset mode is run, so both clock domains start enabled
   localparam logic [1:0]  PMC_CLK_EN_RST    = 2'b11;

   // longest gap between peripheral strobes while waiting: 16 cycles at divisor 15
   localparam int          PMC_WFI_GAP_MAX   = 16;

   typedef enum logic [1:0]
   {
      PMC_RUN,
      PMC_SLOW,
      PMC_WFI,
      PMC_HALT
   } pmc_mode_type;

   typedef struct packed
   {
      logic [PMC_DIV_W-1:0] wfi_div;
      logic [PMC_DIV_W-1:0] ccu_div;
      logic [PMC_DIV_W-1:0] cpu_pre;
      logic [2:0]           unused;
      logic                 slow_en;
   } pmc_ctrl_type;

   // events from instruction decode and the interrupt controller
   typedef struct packed
   {
      logic wfi_exec;
      logic halt_exec;
      logic irq_ack;
   } pmc_core_evt_type;

   // clock enables towards the clock tree gates
   typedef struct packed
   {
      logic cpu;
      logic periph;
   } pmc_clk_en_type;

   typedef struct packed
   {
      pmc_mode_type   mode;
      pmc_ctrl_type   ctrl;
      logic           halt_refused;
      pmc_clk_en_type clk_en;
   } pmc_top_state_type;

   typedef struct packed
   {
      logic        ack;
      logic [31:0] rdata;
   } pmc_bus_state_type;

endpackage

/* logic/pmc_top.sv */
// power mode sequencing and clock gating enables for the processor core
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps

// What this block does
// - run mode: cpu and peripherals at full rate
// - slow mode: prescaler and divider lower rates
// - wait instruction stops execution until interrupt acknowledged
// - waiting: cpu clock off, peripherals at chosen rate
// - halt without watchdog freezes all clocks
// - halt left only through reset
module pmc_top
   import pmc_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  reset_n,
   input  wire logic [PMC_ADDR_W-1:0] avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   output      logic [31:0]           avs_readdata,
   output      logic                  avs_waitrequest,
   input  wire pmc_core_evt_type      core_evt,
   input  wire logic                  wdg_enabled,
   output      pmc_clk_en_type        clk_en,
   output      pmc_mode_type          power_mode,
   output      logic                  halted
);

   pmc_top_state_type s_r;
   pmc_top_state_type s_nxt;

   logic        wr_fire;
   logic [31:0] rdata_in;
   logic        ccu_tick;
   logic        cpu_tick;
   logic        wfi_tick;
   logic        active;

   assign active     = (s_r.mode == PMC_RUN) || (s_r.mode == PMC_SLOW);
   assign clk_en     = s_r.clk_en;
   assign power_mode = s_r.mode;
   assign halted     = (s_r.mode == PMC_HALT);

   pmc_bus_slave u_bus
   (
      .core_clk        (core_clk),
      .reset_n         (reset_n),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .rdata_in        (rdata_in),
      .avs_waitrequest (avs_waitrequest),
      .avs_readdata    (avs_readdata),
      .wr_fire         (wr_fire)
   );

   // clock unit divider, field 0 already divides by two so slow is always slower
   pmc_clk_div #(.W(PMC_DIV_W + 1)) u_ccu_div
   (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .step     (1'b1),
      .divisor  ((PMC_DIV_W + 1)'({1'b0, s_r.ctrl.ccu_div} + 1'b1)),
      .tick     (ccu_tick)
   );

   // processor prescaler counts clock unit ticks
   pmc_clk_div #(.W(PMC_DIV_W + 1)) u_cpu_pre
   (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .step     (ccu_tick),
      .divisor  ({1'b0, s_r.ctrl.cpu_pre}),
      .tick     (cpu_tick)
   );

   // peripheral and interrupt controller rate while waiting
   pmc_clk_div #(.W(PMC_DIV_W + 1)) u_wfi_div
   (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .step     (1'b1),
      .divisor  ({1'b0, s_r.ctrl.wfi_div}),
      .tick     (wfi_tick)
   );

   // register read mux, unmapped offsets read zero
   always_comb
   begin
      rdata_in = 32'h0000_0000;
      case (avs_address)
         PMC_OFS_CTRL:
            rdata_in = {16'h0000, s_r.ctrl};
         PMC_OFS_STATUS:
         begin
            rdata_in[PMC_STAT_MODE_POS +: 2] = s_r.mode;
            rdata_in[PMC_STAT_WDG_POS]       = wdg_enabled;
            rdata_in[PMC_STAT_HREF_POS]      = s_r.halt_refused;
         end
         default:
            rdata_in = 32'h0000_0000;
      endcase
   end

   always_comb
   begin
      s_nxt = s_r;

      case (s_r.mode)
         PMC_RUN, PMC_SLOW:
         begin
            if (core_evt.halt_exec && !wdg_enabled)
               s_nxt.mode = PMC_HALT;
            else if (core_evt.wfi_exec)
               s_nxt.mode = PMC_WFI;
            else if (s_r.ctrl.slow_en)
               s_nxt.mode = PMC_SLOW;
            else
               s_nxt.mode = PMC_RUN;
         end
         PMC_WFI:
         begin
            // only an acknowledged interrupt resumes execution
            if (core_evt.irq_ack)
               s_nxt.mode = s_r.ctrl.slow_en ? PMC_SLOW : PMC_RUN;
         end
         PMC_HALT:
            s_nxt.mode = PMC_HALT;
         default:
            s_nxt.mode = PMC_RUN;
      endcase

      // control writes are ignored once frozen
      if (wr_fire && avs_address == PMC_OFS_CTRL && s_r.mode != PMC_HALT)
         s_nxt.ctrl = pmc_ctrl_type'({avs_writedata[15:4], 3'b000,
                                      avs_writedata[PMC_CTRL_SLOW_POS]});

      // write one to clear, a new refusal in the same cycle wins
      if (wr_fire && avs_address == PMC_OFS_STATUS && avs_writedata[PMC_STAT_HREF_POS])
         s_nxt.halt_refused = 1'b0;
      if (active && core_evt.halt_exec && wdg_enabled)
         s_nxt.halt_refused = 1'b1;

      case (s_nxt.mode)
         PMC_RUN:
         begin
            s_nxt.clk_en.cpu    = 1'b1;
            s_nxt.clk_en.periph = 1'b1;
         end
         PMC_SLOW:
         begin
            s_nxt.clk_en.cpu    = cpu_tick;
            s_nxt.clk_en.periph = ccu_tick;
         end
         PMC_WFI:
         begin
            s_nxt.clk_en.cpu    = 1'b0;
            s_nxt.clk_en.periph = wfi_tick;
         end
         PMC_HALT:
         begin
            s_nxt.clk_en.cpu    = 1'b0;
            s_nxt.clk_en.periph = 1'b0;
         end
         default:
         begin
            s_nxt.clk_en.cpu    = 1'b0;
            s_nxt.clk_en.periph = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_r.mode         <= PMC_RUN;
         s_r.ctrl         <= pmc_ctrl_type'(PMC_CTRL_RST);
         s_r.halt_refused <= PMC_HREF_RST;
         s_r.clk_en       <= pmc_clk_en_type'(PMC_CLK_EN_RST);
      end
      else
         s_r <= s_nxt;
   end

   // gap counter between peripheral strobes while waiting, for checking only
   logic [5:0] wfi_gap_r;

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         wfi_gap_r <= 6'h00;
      else if (s_r.mode != PMC_WFI || s_r.clk_en.periph)
         wfi_gap_r <= 6'h00;
      else if (wfi_gap_r != 6'h3F)
         wfi_gap_r <= wfi_gap_r + 6'h01;
   end

   // gap counter between peripheral strobes in slow mode, for checking only
   logic [5:0] slow_gap_r;

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         slow_gap_r <= 6'h00;
      else if (s_r.mode != PMC_SLOW || s_r.clk_en.periph)
         slow_gap_r <= 6'h00;
      else if (slow_gap_r != 6'h3F)
         slow_gap_r <= slow_gap_r + 6'h01;
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   chk_run_full_rate: assert property (
      (power_mode == PMC_RUN) |-> (clk_en.cpu && clk_en.periph))
      else $error("run mode without both clocks enabled");

   chk_slow_cpu_rate: assert property (
      (power_mode == PMC_SLOW && clk_en.cpu) |=> !(power_mode == PMC_SLOW && clk_en.cpu))
      else $error("slow mode cpu clock enabled on consecutive cycles");

   chk_slow_periph_rate: assert property (
      (power_mode == PMC_SLOW && clk_en.periph)
         |=> !(power_mode == PMC_SLOW && clk_en.periph))
      else $error("slow mode peripheral clock at full rate");

   chk_wfi_entry: assert property (
      (active && core_evt.wfi_exec && !core_evt.halt_exec) |=> (power_mode == PMC_WFI))
      else $error("wait instruction did not stop execution");

   chk_wfi_hold: assert property (
      (power_mode == PMC_WFI && !core_evt.irq_ack) |=> (power_mode == PMC_WFI))
      else $error("left wait without interrupt acknowledge");

   chk_wfi_cpu_stop: assert property (
      (power_mode == PMC_WFI) |-> !clk_en.cpu)
      else $error("cpu clock running while waiting");

   chk_wfi_periph_live: assert property (
      (power_mode == PMC_WFI) |-> (wfi_gap_r <= 6'(PMC_WFI_GAP_MAX)))
      else $error("peripheral clock stalled while waiting");

   chk_halt_entry: assert property (
      (active && core_evt.halt_exec && !wdg_enabled)
         |=> (halted && !clk_en.cpu && !clk_en.periph) [*3])
      else $error("halt did not freeze clocks");

   chk_halt_stick: assert property (
      halted |=> (halted && $stable(s_r.ctrl)))
      else $error("halt state left without reset");

   chk_halt_refused: assert property (
      (active && core_evt.halt_exec && wdg_enabled) |=> (!halted && s_r.halt_refused))
      else $error("halt taken while watchdog enabled");

   chk_run_select: assert property (
      (active && !s_r.ctrl.slow_en && !core_evt.wfi_exec && !core_evt.halt_exec)
         |=> (power_mode == PMC_RUN))
      else $error("run mode not selected with slow mode off");

   chk_slow_select: assert property (
      (active && s_r.ctrl.slow_en && !core_evt.wfi_exec && !core_evt.halt_exec)
         |=> (power_mode == PMC_SLOW))
      else $error("slow mode not selected with slow mode on");

   chk_slow_periph_gap: assert property (
      (power_mode == PMC_SLOW) |-> (slow_gap_r <= 6'(PMC_WFI_GAP_MAX)))
      else $error("peripheral clock stalled in slow mode");

   chk_wfi_resume: assert property (
      (power_mode == PMC_WFI && core_evt.irq_ack)
         |=> (power_mode == PMC_RUN || power_mode == PMC_SLOW))
      else $error("acknowledged interrupt did not resume execution");

   chk_halt_no_wake: assert property (
      (halted && (core_evt.irq_ack || core_evt.wfi_exec || core_evt.halt_exec)) |=> halted)
      else $error("event took the block out of halt");

   chk_refused_running: assert property (
      (active && core_evt.halt_exec && wdg_enabled && !core_evt.wfi_exec) |=> active)
      else $error("halt with watchdog enabled stopped execution");

   chk_bus_one_wait: assert property (
      avs_waitrequest |=> !avs_waitrequest)
      else $error("bus access held more than one wait cycle");

   cov_wfi_round: cover property (
      (power_mode == PMC_WFI) ##[1:50] (power_mode != PMC_WFI));

   cov_slow_cpu: cover property (
      (power_mode == PMC_SLOW && clk_en.cpu) ##[2:40] (power_mode == PMC_SLOW && clk_en.cpu));

   cov_halt: cover property (
      active ##1 halted);

   cov_refused: cover property (
      active && core_evt.halt_exec && wdg_enabled);

   cov_wfi_from_slow: cover property (
      (power_mode == PMC_SLOW) ##1 (power_mode == PMC_WFI));

endmodule

/* test/pmc_core_model.sv */
// behavioural processor core, interrupt controller and watchdog
`timescale 1ns/1ps
module pmc_core_model
   import pmc_pkg::*;
(
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   input  wire logic             go_wfi,
   input  wire logic             go_halt,
   input  wire logic             force_ack,
   input  wire logic             wdg_req,
   input  wire logic [7:0]       ack_dly,
   input  wire pmc_mode_type     power_mode,
   output      pmc_core_evt_type core_evt,
   output      logic             wdg_enabled
);
   logic [7:0] cnt_r;
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         core_evt    <= '0;
         wdg_enabled <= 1'b0;
         cnt_r       <= 8'h00;
      end
      else
      begin
         core_evt.wfi_exec  <= go_wfi;
         core_evt.halt_exec <= go_halt;
         wdg_enabled        <= wdg_req;
         cnt_r              <= (power_mode == PMC_WFI) ? cnt_r + 8'h01 : 8'h00;
         // acknowledge after the chosen wait, or on command at any time
         core_evt.irq_ack   <= force_ack | (power_mode == PMC_WFI && cnt_r == ack_dly);
      end
   end
endmodule

/* test/test_pmc_top.sv */
// self-checking bench of the power mode and clock gating block
`timescale 1ns/1ps
module test_pmc_top;
   import pmc_pkg::*;
   logic                  core_clk = 1'b0;
   logic                  reset_n = 1'b0;
   logic [PMC_ADDR_W-1:0] avs_address = 4'h0;
   logic                  avs_read = 1'b0;
   logic                  avs_write = 1'b0;
   logic [31:0]           avs_writedata = 32'h0;
   logic [31:0]           avs_readdata;
   logic                  avs_waitrequest;
   pmc_core_evt_type      core_evt;
   logic                  wdg_enabled;
   pmc_clk_en_type        clk_en;
   pmc_mode_type          power_mode;
   logic                  halted;
   logic                  go_wfi = 1'b0, go_halt = 1'b0, force_ack = 1'b0, wdg_req = 1'b0;
   logic [7:0]            ack_dly = 8'h00;
   logic [31:0]           exp_q[$];
   int                    miscompares = 0, total_checks = 0, seed = 32'h5e871dc6;
   int                    g, n;
   logic [3:0]            pre, cdv, wdv;
   logic [15:0]           ctrl;

   initial forever #2.5 core_clk = ~core_clk;

   pmc_top pmc_top_inst (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core_evt(core_evt),
      .wdg_enabled(wdg_enabled), .clk_en(clk_en), .power_mode(power_mode), .halted(halted));
   pmc_core_model pmc_core_model_inst (.core_clk(core_clk), .reset_n(reset_n), .go_wfi(go_wfi),
      .go_halt(go_halt), .force_ack(force_ack), .wdg_req(wdg_req), .ack_dly(ack_dly),
      .power_mode(power_mode), .core_evt(core_evt), .wdg_enabled(wdg_enabled));

   task automatic tally_and_finish();
      if (miscompares == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic tout();
      miscompares++;
      $display("CHECK FAILED %0t wait ran out", $time);
      tally_and_finish();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // one bus cycle, held until waitrequest is seen low at an edge
   task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
      int k;
      @(posedge core_clk);
      avs_address <= a;
      avs_read <= rd;
      avs_write <= ~rd;
      avs_writedata <= d;
      k = 0;
      do
      begin
         @(posedge core_clk);
         k++;
         if (k > 50) tout();
      end
      while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic bus_read(input logic [3:0] a, input logic [31:0] exp);
      exp_q.push_back(exp);
      bus(1'b1, a, 32'h0);
   endtask
   always @(posedge core_clk)
      if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
         chk(avs_readdata, exp_q.pop_front(), "read data");
   task automatic evt(input int k);
      @(posedge core_clk);
      go_wfi <= (k == 0);
      go_halt <= (k == 1);
      force_ack <= (k == 2);
      @(posedge core_clk);
      go_wfi <= 1'b0;
      go_halt <= 1'b0;
      force_ack <= 1'b0;
   endtask
   task automatic wait_mode(input pmc_mode_type m);
      int k;
      k = 0;
      do
      begin
         @(negedge core_clk);
         k++;
         if (k > 2000) tout();
      end
      while (power_mode !== m);
   endtask
   task automatic wait_sig(input logic [1:0] mask, output int c);
      c = 0;
      while ((clk_en & mask) !== mask)
      begin
         @(negedge core_clk);
         c++;
         if (c > 400) tout();
      end
   endtask
   // cycles between two consecutive enable pulses
   task automatic gap(input logic [1:0] mask, output int r);
      @(negedge core_clk);
      wait_sig(mask, r);
      @(negedge core_clk);
      wait_sig(mask, r);
      r = r + 1;
   endtask
   task automatic hold(input logic [1:0] mask, input logic [1:0] exp, input int c, output int r);
      r = 0;
      repeat (c)
      begin
         @(negedge core_clk);
         if ((clk_en & mask) === exp) r++;
      end
   endtask
   task automatic do_reset();
      reset_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge core_clk);
   endtask

   initial
   begin
      repeat (50000) @(posedge core_clk);
      tout();
   end

   initial
   begin
      do_reset();
      bus_read(PMC_OFS_CTRL, 32'h0);
      bus_read(PMC_OFS_STATUS, 32'h0);
      hold(2'b11, 2'b11, 20, n);
      chk(n, 20, "run enables");
      pre = $random(seed) & 4'h3;
      cdv = $random(seed) & 4'h3;
      wdv = $random(seed);
      ctrl = {wdv, cdv, pre, 3'b000, 1'b1};
      bus(1'b0, PMC_OFS_CTRL, {16'hA5A5, ctrl | 16'h000E});
      bus_read(PMC_OFS_CTRL, {16'h0, ctrl});
      wait_mode(PMC_SLOW);
      gap(2'b01, g);
      chk(g, cdv + 2, "slow periph gap");
      gap(2'b10, g);
      chk(g, (cdv + 2) * (pre + 1), "slow cpu gap");
      @(posedge core_clk);
      ack_dly <= 8'd200;
      evt(0);
      wait_mode(PMC_WFI);
      hold(2'b10, 2'b00, 40, n);
      chk(n, 40, "wait cpu stopped");
      gap(2'b01, g);
      chk(g, wdv + 1, "wait periph gap");
      chk(power_mode, PMC_WFI, "still waiting");
      wait_mode(PMC_SLOW);
      ctrl[0] = 1'b0;
      bus(1'b0, PMC_OFS_CTRL, {16'h0, ctrl});
      wait_mode(PMC_RUN);
      @(posedge core_clk);
      ack_dly <= 8'd2;
      evt(0);
      wait_mode(PMC_WFI);
      wait_mode(PMC_RUN);
      hold(2'b11, 2'b11, 4, n);
      chk(n, 4, "run after wake");
      @(posedge core_clk);
      wdg_req <= 1'b1;
      evt(1);
      hold(2'b11, 2'b11, 10, n);
      chk(n, 10, "halt refused clocks");
      chk({power_mode, halted}, {PMC_RUN, 1'b0}, "halt refused mode");
      bus_read(PMC_OFS_STATUS, 32'h14);
      bus(1'b0, PMC_OFS_STATUS, 32'h10);
      bus_read(PMC_OFS_STATUS, 32'h04);
      wdg_req <= 1'b0;
      evt(1);
      wait_mode(PMC_HALT);
      chk(halted, 1'b1, "halted flag");
      hold(2'b11, 2'b00, 20, n);
      chk(n, 20, "halt clocks stopped");
      evt(2);
      evt(0);
      bus(1'b0, PMC_OFS_CTRL, 32'h1);
      bus_read(PMC_OFS_CTRL, {16'h0, ctrl});
      bus_read(4'h8, 32'h0);
      hold(2'b11, 2'b00, 8, n);
      chk({power_mode, n[3:0]}, {PMC_HALT, 4'h8}, "halt kept");
      @(posedge core_clk);
      do_reset();
      @(negedge core_clk);
      chk({power_mode, halted, clk_en}, {PMC_RUN, 1'b0, 2'b11}, "out by reset");
      bus_read(PMC_OFS_STATUS, 32'h0);
      repeat (3) @(posedge core_clk);
      tally_and_finish();
   end
endmodule
